//--- core/ahm_master.sv
`timescale 1ns/1ns
`include "ahm_consts.svh"
module ahm_master #(
  parameter int ADDR_W = `AHM_ADDR_W_DEF,
  parameter int DATA_W = `AHM_DATA_W_DEF,
  parameter int AUSER_W = `AHM_USER_W_DEF,
  parameter int WUSER_W = `AHM_USER_W_DEF,
  parameter int RUSER_W = `AHM_USER_W_DEF,
  localparam int AUW = (AUSER_W == 0) ? 1 : AUSER_W,
  localparam int WUW = (WUSER_W == 0) ? 1 : WUSER_W,
  localparam int RUW = (RUSER_W == 0) ? 1 : RUSER_W
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  ahm_if.master bus,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic cmd_write_in,
  input wire logic [2:0] cmd_size_in,
  input wire ahm_pkg::ahm_burst_type cmd_burst_in,
  input wire logic [3:0] cmd_prot_in,
  input wire logic cmd_lock_in,
  input wire logic [DATA_W-1:0] cmd_wdata_in,
  input wire logic [WUW-1:0] cmd_wuser_in,
  input wire logic [AUW-1:0] cmd_auser_in,
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic [RUW-1:0] rsp_ruser_out,
  output logic rsp_err_out,
  output logic rsp_write_out
);
  import ahm_pkg::*;
  localparam int EW = DATA_W + RUW + 2;

  // Command holding slot
  logic pv_q, pv_d, crdy_q, crdy_d;
  logic [ADDR_W-1:0] pa_q, pa_d;
  logic pw_q, pw_d, pl_q, pl_d;
  logic [2:0] ps_q, ps_d, pb_q, pb_d;
  logic [3:0] pp_q, pp_d;
  logic [DATA_W-1:0] pwd_q, pwd_d;
  logic [WUW-1:0] pwu_q, pwu_d;
  logic [AUW-1:0] pau_q, pau_d;

  // Address phase
  ahm_mstate_type st_q, st_d;
  logic [4:0] left_q, left_d;
  logic [ADDR_W-1:0] haddr_q, haddr_d;
  logic [2:0] hburst_q, hburst_d, hsize_q, hsize_d;
  logic hlock_q, hlock_d, hwrite_q, hwrite_d;
  logic [3:0] hprot_q, hprot_d;
  ahm_trans_type htrans_q, htrans_d;
  logic [AUW-1:0] hauser_q, hauser_d;
  logic [DATA_W-1:0] awd_q, awd_d;
  logic [WUW-1:0] awu_q, awu_d;

  // Data phase
  logic dv_q, dv_d, dw_q, dw_d;
  logic [DATA_W-1:0] hwdata_q, hwdata_d;
  logic [WUW-1:0] hwuser_q, hwuser_d;

  // Two-entry response buffer, head drives the user outputs
  logic b0v_q, b0v_d, b1v_q, b1v_d;
  logic [EW-1:0] b0_q, b0_d, b1_q, b1_d, ent;

  logic ap_v, pop, push, room, take;
  logic [2:0] outst;

  assign ap_v = htrans_q == `AHM_TRANS_NONSEQ || htrans_q == `AHM_TRANS_SEQ;
  assign pop = b0v_q && rsp_ready_in;
  // A write completion carries only its response
  assign push = bus.hready && dv_q;
  // Every issued beat owns a buffer slot, so a stalled reader never loses a word
  assign outst = 3'({2'h0, b0v_q}) + 3'({2'h0, b1v_q}) + 3'({2'h0, dv_q})
    + 3'({2'h0, ap_v}) - 3'({2'h0, pop});
  assign room = outst < `AHM_BUF_DEPTH;
  assign take = bus.hready && pv_q && room;
  assign ent = {dw_q ? '0 : bus.hrdata,
    (RUSER_W == 0 || dw_q) ? RUW'(0) : bus.hruser,
    bus.hresp == `AHM_RESP_ERROR, dw_q};

  always_comb begin
    pv_d = pv_q && !take;
    {pa_d, pw_d, pl_d, ps_d, pb_d, pp_d, pwd_d, pwu_d, pau_d} =
      {pa_q, pw_q, pl_q, ps_q, pb_q, pp_q, pwd_q, pwu_q, pau_q};
    if (cmd_valid_in && crdy_q) begin
      pv_d = 1'b1;
      {pa_d, pw_d, pl_d, ps_d, pb_d, pp_d, pwd_d, pwu_d, pau_d} = {cmd_addr_in, cmd_write_in,
        cmd_lock_in, cmd_size_in, cmd_burst_in, cmd_prot_in, cmd_wdata_in, cmd_wuser_in,
        cmd_auser_in};
    end
    crdy_d = !pv_d;
  end

  always_comb begin
    st_d = st_q;
    left_d = left_q;
    haddr_d = haddr_q;
    hburst_d = hburst_q;
    hsize_d = hsize_q;
    hlock_d = hlock_q;
    hwrite_d = hwrite_q;
    hprot_d = hprot_q;
    htrans_d = htrans_q;
    hauser_d = hauser_q;
    awd_d = awd_q;
    awu_d = awu_q;
    dv_d = dv_q;
    dw_d = dw_q;
    hwdata_d = hwdata_q;
    hwuser_d = hwuser_q;
    // Nothing moves while the slave stretches the phase
    if (bus.hready) begin
      dv_d = ap_v;
      dw_d = hwrite_q;
      hwdata_d = hwrite_q ? awd_q : '0;
      hwuser_d = (WUSER_W == 0 || !hwrite_q) ? '0 : awu_q;
      case (st_q)
        AHM_MST_IDLE: begin
          if (take) begin
            htrans_d = `AHM_TRANS_NONSEQ;
            haddr_d = pa_q;
            hburst_d = pb_q;
            hsize_d = ps_q;
            hprot_d = pp_q;
            hlock_d = pl_q;
            hwrite_d = pw_q;
            hauser_d = (AUSER_W == 0) ? '0 : pau_q;
            awd_d = pwd_q;
            awu_d = pwu_q;
            left_d = ahm_beats(pb_q) - 5'h01;
            st_d = (ahm_beats(pb_q) > `AHM_BEATS_1) ? AHM_MST_BURST : AHM_MST_IDLE;
          end else begin
            htrans_d = `AHM_TRANS_IDLE;
            hlock_d = 1'b0;
          end
        end
        AHM_MST_BURST: begin
          // Burst control is frozen; only address and data follow the command
          if (take) begin
            htrans_d = `AHM_TRANS_SEQ;
            haddr_d = pa_q;
            hauser_d = (AUSER_W == 0) ? '0 : pau_q;
            awd_d = pwd_q;
            awu_d = pwu_q;
            left_d = left_q - 5'h01;
            st_d = (left_q == `AHM_BEATS_1) ? AHM_MST_IDLE : AHM_MST_BURST;
          end else begin
            htrans_d = `AHM_TRANS_BUSY;
          end
        end
        default: begin
          st_d = AHM_MST_IDLE;
          htrans_d = `AHM_TRANS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    b0v_d = b0v_q;
    b1v_d = b1v_q;
    b0_d = b0_q;
    b1_d = b1_q;
    if (pop) begin
      b0v_d = b1v_q;
      b0_d = b1_q;
      b1v_d = 1'b0;
    end
    if (push) begin
      if (!b0v_d) begin
        b0v_d = 1'b1;
        b0_d = ent;
      end else begin
        b1v_d = 1'b1;
        b1_d = ent;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pv_q <= 1'b0;
      crdy_q <= 1'b1;
      {pa_q, pw_q, pl_q, ps_q, pb_q, pp_q, pwd_q, pwu_q, pau_q} <= '0;
      st_q <= AHM_MST_IDLE;
      left_q <= '0;
      haddr_q <= '0;
      hburst_q <= `AHM_BURST_SINGLE;
      hsize_q <= '0;
      hlock_q <= 1'b0;
      hwrite_q <= 1'b0;
      hprot_q <= '0;
      htrans_q <= `AHM_TRANS_IDLE;
      hauser_q <= '0;
      awd_q <= '0;
      awu_q <= '0;
      dv_q <= 1'b0;
      dw_q <= 1'b0;
      hwdata_q <= '0;
      hwuser_q <= '0;
      b0v_q <= 1'b0;
      b1v_q <= 1'b0;
      b0_q <= '0;
      b1_q <= '0;
    end else begin
      pv_q <= pv_d;
      crdy_q <= crdy_d;
      {pa_q, pw_q, pl_q, ps_q, pb_q, pp_q, pwd_q, pwu_q, pau_q} <=
        {pa_d, pw_d, pl_d, ps_d, pb_d, pp_d, pwd_d, pwu_d, pau_d};
      st_q <= st_d;
      left_q <= left_d;
      haddr_q <= haddr_d;
      hburst_q <= hburst_d;
      hsize_q <= hsize_d;
      hlock_q <= hlock_d;
      hwrite_q <= hwrite_d;
      hprot_q <= hprot_d;
      htrans_q <= htrans_d;
      hauser_q <= hauser_d;
      awd_q <= awd_d;
      awu_q <= awu_d;
      dv_q <= dv_d;
      dw_q <= dw_d;
      hwdata_q <= hwdata_d;
      hwuser_q <= hwuser_d;
      b0v_q <= b0v_d;
      b1v_q <= b1v_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
    end
  end

  assign bus.haddr = haddr_q;
  assign bus.hburst = hburst_q;
  assign bus.hmastlock = hlock_q;
  assign bus.hprot = hprot_q;
  assign bus.hsize = hsize_q;
  assign bus.htrans = htrans_q;
  assign bus.hwrite = hwrite_q;
  assign bus.hwdata = hwdata_q;
  assign bus.hwuser = hwuser_q;
  assign bus.hauser = hauser_q;
  assign cmd_ready_out = crdy_q;
  assign rsp_valid_out = b0v_q;
  assign rsp_rdata_out = b0_q[EW-1 -: DATA_W];
  assign rsp_ruser_out = b0_q[RUW+1:2];
  assign rsp_err_out = b0_q[1];
  assign rsp_write_out = b0_q[0];
endmodule

//--- core/ahm_consts.svh
`ifndef AHM_CONSTS_SVH
`define AHM_CONSTS_SVH
`define AHM_ADDR_W_DEF 32
`define AHM_DATA_W_DEF 32
`define AHM_USER_W_DEF 0
`define AHM_TRANS_IDLE 2'h0
`define AHM_TRANS_BUSY 2'h1
`define AHM_TRANS_NONSEQ 2'h2
`define AHM_TRANS_SEQ 2'h3
`define AHM_BURST_SINGLE 3'h0
`define AHM_BURST_INCR 3'h1
`define AHM_BURST_WRAP4 3'h2
`define AHM_BURST_INCR4 3'h3
`define AHM_BURST_WRAP8 3'h4
`define AHM_BURST_INCR8 3'h5
`define AHM_BURST_WRAP16 3'h6
`define AHM_BURST_INCR16 3'h7
`define AHM_BEATS_1 5'h01
`define AHM_BEATS_4 5'h04
`define AHM_BEATS_8 5'h08
`define AHM_BEATS_16 5'h10
`define AHM_RESP_OKAY 1'h0
`define AHM_RESP_ERROR 1'h1
`define AHM_BUF_DEPTH 3'h2
`define AHM_MST_IDLE 2'h1
`define AHM_MST_BURST 2'h2
`define AHM_SLV_IDLE 4'h1
`define AHM_SLV_DATA 4'h2
`define AHM_SLV_WAIT 4'h4
`define AHM_SLV_ERR 4'h8
`endif

//--- core/ahm_pkg.sv
package ahm_pkg;
`include "ahm_consts.svh"
  typedef enum logic [1:0] {
    AHM_MST_IDLE = `AHM_MST_IDLE,
    AHM_MST_BURST = `AHM_MST_BURST
  } ahm_mstate_type;
  typedef enum logic [3:0] {
    AHM_SLV_IDLE = `AHM_SLV_IDLE,
    AHM_SLV_DATA = `AHM_SLV_DATA,
    AHM_SLV_WAIT = `AHM_SLV_WAIT,
    AHM_SLV_ERR = `AHM_SLV_ERR
  } ahm_sstate_type;
  typedef logic [1:0] ahm_trans_type;
  typedef logic [2:0] ahm_burst_type;

  // Undefined-length bursts are not supported and run as single beats
  function automatic logic [4:0] ahm_beats(input ahm_burst_type b);
    logic [4:0] n;
    case (b)
      `AHM_BURST_WRAP4, `AHM_BURST_INCR4: n = `AHM_BEATS_4;
      `AHM_BURST_WRAP8, `AHM_BURST_INCR8: n = `AHM_BEATS_8;
      `AHM_BURST_WRAP16, `AHM_BURST_INCR16: n = `AHM_BEATS_16;
      default: n = `AHM_BEATS_1;
    endcase
    return n;
  endfunction
endpackage

//--- core/ahm_if.sv
`timescale 1ns/1ns
interface ahm_if #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int AUSER_W = 0,
  parameter int WUSER_W = 0,
  parameter int RUSER_W = 0
) ();
  // Zero-width sideband keeps a one-bit stub that carries constant zero
  localparam int AUW = (AUSER_W == 0) ? 1 : AUSER_W;
  localparam int WUW = (WUSER_W == 0) ? 1 : WUSER_W;
  localparam int RUW = (RUSER_W == 0) ? 1 : RUSER_W;
  logic [ADDR_W-1:0] haddr;
  logic [2:0] hburst;
  logic hmastlock;
  logic [3:0] hprot;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic hwrite;
  logic [DATA_W-1:0] hwdata;
  logic [WUW-1:0] hwuser;
  logic [AUW-1:0] hauser;
  logic [DATA_W-1:0] hrdata;
  logic [RUW-1:0] hruser;
  logic hready;
  logic hresp;
  modport master (
    output haddr, hburst, hmastlock, hprot, hsize, htrans, hwrite,
    output hwdata, hwuser, hauser,
    input hrdata, hruser, hready, hresp
  );
  modport slave (
    input haddr, hburst, hmastlock, hprot, hsize, htrans, hwrite,
    input hwdata, hwuser, hauser,
    output hrdata, hruser, hready, hresp
  );
endinterface

//--- core/ahm_slave.sv
`timescale 1ns/1ns
`include "ahm_consts.svh"
module ahm_slave #(
  parameter int ADDR_W = `AHM_ADDR_W_DEF,
  parameter int DATA_W = `AHM_DATA_W_DEF,
  parameter int AUSER_W = `AHM_USER_W_DEF,
  parameter int WUSER_W = `AHM_USER_W_DEF,
  parameter int RUSER_W = `AHM_USER_W_DEF,
  localparam int AUW = (AUSER_W == 0) ? 1 : AUSER_W,
  localparam int WUW = (WUSER_W == 0) ? 1 : WUSER_W,
  localparam int RUW = (RUSER_W == 0) ? 1 : RUSER_W
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  ahm_if.slave bus,
  output logic req_valid_out,
  output logic [ADDR_W-1:0] req_addr_out,
  output logic req_write_out,
  output logic [2:0] req_size_out,
  output ahm_pkg::ahm_burst_type req_burst_out,
  output logic [3:0] req_prot_out,
  output logic req_lock_out,
  output logic [AUW-1:0] req_auser_out,
  output logic [DATA_W-1:0] req_wdata_out,
  output logic [WUW-1:0] req_wuser_out,
  input wire logic rsp_valid_in,
  input wire logic [DATA_W-1:0] rsp_rdata_in,
  input wire logic [RUW-1:0] rsp_ruser_in,
  input wire logic rsp_err_in
);
  import ahm_pkg::*;
  ahm_sstate_type st_q, st_d;
  logic hready_q, hready_d, hresp_q, hresp_d;
  logic [DATA_W-1:0] hrdata_q, hrdata_d, wdata_q, wdata_d;
  logic [RUW-1:0] hruser_q, hruser_d;
  logic [WUW-1:0] wuser_q, wuser_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [AUW-1:0] auser_q, auser_d;
  logic write_q, write_d, lock_q, lock_d, rv_q, rv_d;
  logic [2:0] size_q, size_d, burst_q, burst_d;
  logic [3:0] prot_q, prot_d;
  logic sel;

  assign sel = bus.htrans == `AHM_TRANS_NONSEQ || bus.htrans == `AHM_TRANS_SEQ;

  always_comb begin
    st_d = st_q;
    hready_d = hready_q;
    hresp_d = hresp_q;
    hrdata_d = hrdata_q;
    hruser_d = hruser_q;
    addr_d = addr_q;
    auser_d = auser_q;
    write_d = write_q;
    lock_d = lock_q;
    size_d = size_q;
    burst_d = burst_q;
    prot_d = prot_q;
    wdata_d = wdata_q;
    wuser_d = wuser_q;
    rv_d = rv_q;
    case (st_q)
      AHM_SLV_IDLE: begin
        hresp_d = `AHM_RESP_OKAY;
        hready_d = 1'b1;
        // IDLE and BUSY get a zero-wait OKAY by staying ready
        if (hready_q && sel) begin
          addr_d = bus.haddr;
          auser_d = (AUSER_W == 0) ? '0 : bus.hauser;
          write_d = bus.hwrite;
          lock_d = bus.hmastlock;
          size_d = bus.hsize;
          burst_d = bus.hburst;
          prot_d = bus.hprot;
          hready_d = 1'b0;
          st_d = AHM_SLV_DATA;
        end
      end
      AHM_SLV_DATA: begin
        wdata_d = write_q ? bus.hwdata : '0;
        wuser_d = (WUSER_W == 0 || !write_q) ? '0 : bus.hwuser;
        rv_d = 1'b1;
        st_d = AHM_SLV_WAIT;
      end
      AHM_SLV_WAIT: begin
        if (rv_q && rsp_valid_in) begin
          rv_d = 1'b0;
          hrdata_d = write_q ? '0 : rsp_rdata_in;
          hruser_d = (RUSER_W == 0 || write_q) ? '0 : rsp_ruser_in;
          if (rsp_err_in) begin
            // Two-cycle error so the master can react before completion
            hresp_d = `AHM_RESP_ERROR;
            st_d = AHM_SLV_ERR;
          end else begin
            hresp_d = `AHM_RESP_OKAY;
            hready_d = 1'b1;
            st_d = AHM_SLV_IDLE;
          end
        end
      end
      AHM_SLV_ERR: begin
        hready_d = 1'b1;
        st_d = AHM_SLV_IDLE;
      end
      default: begin
        st_d = AHM_SLV_IDLE;
        hready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= AHM_SLV_IDLE;
      hready_q <= 1'b1;
      hresp_q <= `AHM_RESP_OKAY;
      hrdata_q <= '0;
      hruser_q <= '0;
      addr_q <= '0;
      auser_q <= '0;
      write_q <= 1'b0;
      lock_q <= 1'b0;
      size_q <= '0;
      burst_q <= '0;
      prot_q <= '0;
      wdata_q <= '0;
      wuser_q <= '0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hready_q <= hready_d;
      hresp_q <= hresp_d;
      hrdata_q <= hrdata_d;
      hruser_q <= hruser_d;
      addr_q <= addr_d;
      auser_q <= auser_d;
      write_q <= write_d;
      lock_q <= lock_d;
      size_q <= size_d;
      burst_q <= burst_d;
      prot_q <= prot_d;
      wdata_q <= wdata_d;
      wuser_q <= wuser_d;
      rv_q <= rv_d;
    end
  end

  assign bus.hready = hready_q;
  assign bus.hresp = hresp_q;
  assign bus.hrdata = hrdata_q;
  assign bus.hruser = hruser_q;
  assign req_valid_out = rv_q;
  assign req_addr_out = addr_q;
  assign req_write_out = write_q;
  assign req_size_out = size_q;
  assign req_burst_out = burst_q;
  assign req_prot_out = prot_q;
  assign req_lock_out = lock_q;
  assign req_auser_out = auser_q;
  assign req_wdata_out = wdata_q;
  assign req_wuser_out = wuser_q;
endmodule

//--- tb/ahm_properties.sv
`timescale 1ns/1ns
`include "ahm_consts.svh"
module ahm_properties #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int AUSER_W = 0,
  parameter int WUSER_W = 0,
  parameter int RUSER_W = 0,
  localparam int AUW = (AUSER_W == 0) ? 1 : AUSER_W,
  localparam int WUW = (WUSER_W == 0) ? 1 : WUSER_W,
  localparam int RUW = (RUSER_W == 0) ? 1 : RUSER_W
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [2:0] hburst,
  input wire logic hmastlock,
  input wire logic [3:0] hprot,
  input wire logic [2:0] hsize,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [DATA_W-1:0] hwdata,
  input wire logic [WUW-1:0] hwuser,
  input wire logic [AUW-1:0] hauser,
  input wire logic [DATA_W-1:0] hrdata,
  input wire logic [RUW-1:0] hruser,
  input wire logic hready,
  input wire logic hresp
);
  import ahm_pkg::*;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  a_ctrl_held:
    assert property (!hready |=> $stable({haddr, hburst, hmastlock, hprot, hsize, htrans,
      hwrite, hauser})) else $error("address phase moved while waited");
  a_wdata_held:
    assert property (!hready |=> $stable({hwdata, hwuser}))
      else $error("write data moved while waited");
  a_lock_idle:
    assert property (htrans == `AHM_TRANS_IDLE |-> !hmastlock)
      else $error("lock high with no transfer");
  a_seq_cont:
    assert property (htrans == `AHM_TRANS_SEQ |-> $past(htrans) != `AHM_TRANS_IDLE
      && $stable(hburst) && $stable(hmastlock)) else $error("sequential beat out of burst");
  a_single_end:
    assert property (hready && htrans == `AHM_TRANS_NONSEQ && hburst inside {`AHM_BURST_SINGLE,
      `AHM_BURST_INCR} |=> htrans inside {`AHM_TRANS_IDLE, `AHM_TRANS_NONSEQ})
      else $error("single transfer continued as burst");
  a_beat_wait:
    assert property (hready && htrans inside {`AHM_TRANS_NONSEQ, `AHM_TRANS_SEQ} |=> !hready)
      else $error("beat completed without wait state");
  a_idle_okay:
    assert property (hready && htrans inside {`AHM_TRANS_IDLE, `AHM_TRANS_BUSY}
      |=> hready && !hresp) else $error("idle transfer not answered okay");
  a_err_pair:
    assert property (hresp && !hready |=> hresp && hready)
      else $error("error response not two cycles");
  a_ruser_zero:
    assert property (RUSER_W != 0 || hruser == '0)
      else $error("removed sideband not zero");

  cover property (hready && htrans == `AHM_TRANS_NONSEQ && hwrite);
  cover property (hready && htrans == `AHM_TRANS_SEQ && !hwrite);
  cover property (hresp && !hready);
  cover property (htrans == `AHM_TRANS_BUSY);
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ns
`include "ahm_consts.svh"
module testbench;
  import ahm_pkg::*;
  localparam int UW = 8;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cmd_valid_in = 1'b0, cmd_write_in = 1'b0, cmd_lock_in = 1'b0;
  logic rsp_ready_in = 1'b0, rsp_valid_in = 1'b0, rsp_err_in = 1'b0;
  logic [2:0] cmd_size_in = 3'h0;
  ahm_burst_type cmd_burst_in = 3'h0;
  logic [3:0] cmd_prot_in = 4'h0;
  logic [31:0] cmd_addr_in = 32'h0, cmd_wdata_in = 32'h0, rsp_rdata_in = 32'h0;
  logic [UW-1:0] cmd_wuser_in = 8'h0, cmd_auser_in = 8'h0;
  logic [0:0] rsp_ruser_in = 1'h0;
  logic cmd_ready_out, rsp_valid_out, rsp_err_out, rsp_write_out;
  logic req_valid_out, req_write_out, req_lock_out;
  logic [31:0] rsp_rdata_out, req_wdata_out, req_addr_out;
  logic [0:0] rsp_ruser_out;
  logic [2:0] req_size_out;
  ahm_burst_type req_burst_out;
  logic [3:0] req_prot_out;
  logic [UW-1:0] req_auser_out, req_wuser_out;
  logic [91:0] exp_req_q[$];
  logic [34:0] exp_rsp_q[$];
  logic [91:0] exp_r, got_r;
  logic hold_ready = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int seed;

  ahm_if #(.AUSER_W(UW), .WUSER_W(UW)) bus ();
  ahm_master #(.AUSER_W(UW), .WUSER_W(UW)) ahm_master_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .bus(bus.master),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_addr_in(cmd_addr_in),
    .cmd_write_in(cmd_write_in), .cmd_size_in(cmd_size_in), .cmd_burst_in(cmd_burst_in),
    .cmd_prot_in(cmd_prot_in), .cmd_lock_in(cmd_lock_in), .cmd_wdata_in(cmd_wdata_in),
    .cmd_wuser_in(cmd_wuser_in), .cmd_auser_in(cmd_auser_in), .rsp_valid_out(rsp_valid_out),
    .rsp_ready_in(rsp_ready_in), .rsp_rdata_out(rsp_rdata_out), .rsp_ruser_out(rsp_ruser_out),
    .rsp_err_out(rsp_err_out), .rsp_write_out(rsp_write_out));
  ahm_slave #(.AUSER_W(UW), .WUSER_W(UW)) ahm_slave_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .bus(bus.slave),
    .req_valid_out(req_valid_out), .req_addr_out(req_addr_out), .req_write_out(req_write_out),
    .req_size_out(req_size_out), .req_burst_out(req_burst_out), .req_prot_out(req_prot_out),
    .req_lock_out(req_lock_out), .req_auser_out(req_auser_out), .req_wdata_out(req_wdata_out),
    .req_wuser_out(req_wuser_out), .rsp_valid_in(rsp_valid_in), .rsp_rdata_in(rsp_rdata_in),
    .rsp_ruser_in(rsp_ruser_in), .rsp_err_in(rsp_err_in));
  ahm_properties #(.AUSER_W(UW), .WUSER_W(UW)) ahm_properties_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .haddr(bus.haddr), .hburst(bus.hburst),
    .hmastlock(bus.hmastlock), .hprot(bus.hprot), .hsize(bus.hsize), .htrans(bus.htrans),
    .hwrite(bus.hwrite), .hwdata(bus.hwdata), .hwuser(bus.hwuser), .hauser(bus.hauser),
    .hrdata(bus.hrdata), .hruser(bus.hruser), .hready(bus.hready), .hresp(bus.hresp));

  always #25 clock_in = ~clock_in;

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic check(input logic [91:0] exp, input logic [91:0] got, input string what);
    n_tests++;
    if (got !== exp) begin
      fail($sformatf("%s got %h expected %h", what, got, exp));
    end
  endtask

  task automatic check_req(input logic [91:0] exp, input logic [91:0] got);
    check(exp, got, "request");
  endtask

  task automatic check_rsp(input logic [34:0] exp, input logic [34:0] got);
    check(92'(exp), 92'(got), "response");
  endtask

  task automatic check_idle();
    check(92'h90, 92'({cmd_ready_out, rsp_valid_out, req_valid_out, bus.hready, bus.hresp,
      bus.htrans, bus.hmastlock}), "idle state");
  endtask

  // Random far-end pacing; stray read data each cycle exposes a mis-timed capture
  always @(posedge clock_in) begin
    rsp_valid_in <= ($random(seed) & 3) != 0;
    rsp_rdata_in <= $random(seed);
    rsp_ruser_in <= 1'($random(seed));
    rsp_err_in <= ($random(seed) & 7) == 0;
    rsp_ready_in <= !hold_ready && (($random(seed) & 3) != 0);
  end

  always @(posedge clock_in) begin
    if (reset_n_in && req_valid_out && rsp_valid_in) begin
      exp_r = exp_req_q.pop_front();
      got_r = {req_addr_out, req_write_out, req_size_out, req_burst_out, req_prot_out,
        req_lock_out, req_auser_out, req_wdata_out, req_wuser_out};
      check_req(exp_r, got_r);
      exp_rsp_q.push_back({exp_r[59] ? 32'h0 : rsp_rdata_in, 1'b0, rsp_err_in, exp_r[59]});
    end
    if (reset_n_in && rsp_valid_out && rsp_ready_in) begin
      got_r = 92'({rsp_rdata_out, rsp_ruser_out, rsp_err_out, rsp_write_out});
      check_rsp(exp_rsp_q.pop_front(), got_r[34:0]);
    end
  end

  // Valid stays high across bursts apart from random one-cycle drops before a beat, so back-to-back commands are exercised
  task automatic send_burst(input logic [2:0] burst, input logic write, input logic lock);
    int n;
    int t;
    logic [3:0] prot;
    logic [2:0] size;
    logic [31:0] addr;
    n = burst < 2 ? 1 : burst < 4 ? 4 : burst < 6 ? 8 : 16;
    prot = 4'($random(seed));
    size = 3'(unsigned'($random(seed)) % 3);
    addr = $random(seed) & 32'hFFFF_FF00;
    for (int k = 0; k < n; k++) begin
      if (($random(seed) & 3) == 0) begin
        cmd_valid_in <= 1'b0;
        @(posedge clock_in);
      end
      cmd_valid_in <= 1'b1;
      cmd_addr_in <= addr;
      cmd_write_in <= write;
      cmd_size_in <= size;
      cmd_burst_in <= burst;
      cmd_prot_in <= prot;
      cmd_lock_in <= lock;
      cmd_wdata_in <= $random(seed);
      cmd_wuser_in <= 8'($random(seed));
      cmd_auser_in <= 8'($random(seed));
      for (t = 0; t < 300; t++) begin
        @(posedge clock_in);
        if (cmd_ready_out === 1'b1) break;
      end
      if (t == 300) begin
        fail("command not taken");
        print_verdict();
      end
      exp_req_q.push_back({addr, write, size, burst, prot, lock, cmd_auser_in,
        write ? cmd_wdata_in : 32'h0, write ? cmd_wuser_in : 8'h00});
      addr = addr + (32'h1 << size);
    end
  endtask

  task automatic drain();
    int t;
    cmd_valid_in <= 1'b0;
    for (t = 0; t < 600 && exp_req_q.size() + exp_rsp_q.size() > 0; t++) begin
      @(posedge clock_in);
    end
    if (t == 600) begin
      fail("transfers lost");
      print_verdict();
    end
    repeat (3) @(posedge clock_in);
  endtask

  initial begin
    seed = 32'hea80;
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    #1 check_idle();
    @(posedge clock_in);
    for (int b = 0; b < 16; b++) begin
      send_burst(3'(b), 1'(b >> 3), 1'(b));
    end
    // Receiver stalls long enough to fill the two-entry buffer
    fork
      begin
        hold_ready <= 1'b1;
        repeat (60) @(posedge clock_in);
        hold_ready <= 1'b0;
      end
      begin
        send_burst(3'h3, 1'b1, 1'b0);
        send_burst(3'h5, 1'b0, 1'b1);
      end
    join
    repeat (10) send_burst(3'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    drain();
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    #1 check_idle();
    @(posedge clock_in);
    send_burst(3'h7, 1'b1, 1'b1);
    drain();
    print_verdict();
  end
endmodule
